// [hdl/traffic_pkg.sv]
// Constants, types and register map of the packet traffic tester.
// Assumes a single 40 MHz clock and a synchronous active-low reset.
// How it works
// - Packet count even, from 2 to 65534.
// - Generator and monitor share one count.
// - Generator waits for lock and alignment.
// - Monitor waits link; watches flow, error status.
// - Generator drives flow control and error injection.
// - Lock, alignment, user bus, FIFO, flow control and error signals exchanged.
// - Packet length three segments: SOP, middle, EOP.
// - Packet mode channel counts 0..255, wraps.
// - Burst mode alternates two fixed channels.
// - Restart honoured only while both idle.
// - Simplex transmit waits for remote alignment.
// - Done indicator after all packets sent.
// - Fail indicator on FIFO overflow, underflow.
// - Busy indicator while active; blocks restart.
// - Aligned indicator once alignment achieved.
// - Locked indicators follow transceiver lock.
// - User inputs, outputs pass three registers.
// - At 12.5G one 300 MHz clock.
// - At 25.78125G user 300, core 412 MHz.
// - Bit order reversed toward the transceiver.
package traffic_pkg;
	// Packet count default, even and in range
	localparam int NUM_PKTS_DEF = 100;
	localparam int NUM_PKTS_MIN = 2;
	localparam int NUM_PKTS_MAX = 65534;
	// clock figures of the link variants, in MHz
	localparam int USER_CLK_MHZ = 300;
	localparam int CORE_CLK_FAST_MHZ = 412;
	// Segments per beat and phase of the last beat of a packet pair
	localparam int NSEG = 2;
	localparam logic [1:0] PKT_LAST_PHASE = 2'h2;
	// Burst mode channel pair
	localparam logic [7:0] BURST_CH_A = 8'h05;
	localparam logic [7:0] BURST_CH_B = 8'h0a;
	// Transceiver data width and register stages on user pins
	localparam int XDW = 64;
	localparam int PIN_STAGES = 3;
	// Register byte offsets
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_STAT = 4'h4;
	localparam logic [3:0] OFS_TXCNT = 4'h8;
	localparam logic [3:0] OFS_RXCNT = 4'hc;
	// Control field positions
	localparam int CB_BURST = 0;
	localparam int CB_SIMPLEX = 1;
	localparam int CB_ERRINJ = 2;
	localparam int CB_IN_BAND_FLOW_CONTROL = 3;
	localparam int CB_OUT_OF_BAND_FLOW_CONTROL = 4;
	localparam int CB_RESTART = 5;
	localparam logic [4:0] CTRL_RST = 5'h00;
	// One bus segment
	typedef struct packed {
		logic ena;
		logic sop;
		logic eop;
		logic [7:0] chan;
		logic [31:0] data;
	} seg_t;
	typedef seg_t [NSEG-1:0] beat_t;
	// Generator and monitor states
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_WAIT = 4'h2,
		ST_RUN = 4'h4,
		ST_SPARE = 4'h8
	} tst_state_t;
endpackage : traffic_pkg

// [hdl/stage3_reg.sv]
// Three-stage register for user pins in either direction.
// Assumes clk and rstn of the tester.
`timescale 1ns/1ps
module stage3_reg #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Data
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	// Stage chain; first stage feeds only the second
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;

	// Shift all stages each cycle
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			s1_q <= '0;
			s2_q <= '0;
			dout <= '0;
		end
		else
		begin
			s1_q <= din;
			s2_q <= s1_q;
			dout <= s2_q;
		end
	end
endmodule : stage3_reg

// [hdl/traffic_tester.sv]
// Packet generator and monitor that exercise the protocol core.
// Assumes core status and bus signals on clk; user pins are asynchronous.
//
// The placing of the registers and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps
module traffic_tester #(
	parameter int NUM_PKTS = traffic_pkg::NUM_PKTS_DEF
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Avalon-MM register slave
	input wire logic [3:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Core status
	input wire logic tx_locked,
	input wire logic rx_locked,
	input wire logic rx_aligned,
	input wire logic tx_ovf,
	input wire logic tx_unf,
	input wire logic err_inj_status,
	input wire logic fc_mon_err,
	// Core transmit user bus
	input wire logic tx_rdy,
	output traffic_pkg::beat_t tx_beat,
	// Core receive user bus
	input wire traffic_pkg::beat_t rx_beat,
	// Flow control and error injection drive
	output logic in_band_flow_control_en,
	output logic out_of_band_flow_control_en,
	output logic err_inject,
	// Transceiver data path
	input wire logic [traffic_pkg::XDW-1:0] core_txd,
	output logic [traffic_pkg::XDW-1:0] xcvr_txd,
	input wire logic [traffic_pkg::XDW-1:0] xcvr_rxd,
	output logic [traffic_pkg::XDW-1:0] core_rxd,
	// User pins
	input wire logic restart_pin,
	input wire logic simplex_rx_aligned_pin,
	output logic transmit_transceiver_locked_indicator,
	output logic receive_transceiver_locked_indicator,
	output logic rx_aligned_led,
	output logic tx_done_led,
	output logic tx_fail_led,
	output logic tx_busy_led,
	output logic rx_busy_led,
	output logic rx_fail_led
);
	import traffic_pkg::*;

	// Pair count, since packets leave two per three beats
	localparam logic [15:0] NPAIRS = 16'(NUM_PKTS / 2);
	localparam logic [16:0] NPKTS = 17'(NUM_PKTS);

	// Registers
	logic [4:0] ctrl_q, ctrl_d;
	logic restart_sw_q;
	tst_state_t gen_q, gen_d, mon_q, mon_d;
	logic [1:0] phase_q;
	logic [15:0] pairs_q;
	logic [7:0] ch0_q;
	logic done_q, fail_q, rx_done_q, rx_err_q, fc_err_q, inj_seen_q;
	logic [16:0] rx_cnt_q;
	logic [7:0] exp_ch_q;
	logic restart_prev_q;
	beat_t tx_beat_d;

	// Inputs and indicators through three stages
	logic [1:0] pin_in;
	logic [7:0] led_src, led_out;
	stage3_reg #(.W(2)) u_pin_in (
		.clk(clk),
		.rstn(rstn),
		.din({simplex_rx_aligned_pin, restart_pin}),
		.dout(pin_in)
	);
	stage3_reg #(.W(8)) u_led_out (
		.clk(clk),
		.rstn(rstn),
		.din(led_src),
		.dout(led_out)
	);

	// Decoded controls and status terms
	wire burst = ctrl_q[CB_BURST];
	wire simplex = ctrl_q[CB_SIMPLEX];
	wire gen_busy = (gen_q == ST_WAIT) || (gen_q == ST_RUN);
	wire mon_busy = (mon_q == ST_WAIT) || (mon_q == ST_RUN);
	// link ready from lock and alignment only
	wire link_up = tx_locked && rx_locked && rx_aligned;
	// remote receiver must be aligned in simplex
	wire gen_go = link_up && (!simplex || pin_in[1]);
	wire restart_req = (pin_in[0] && !restart_prev_q) || restart_sw_q;
	wire restart_ok = restart_req && !gen_busy && !mon_busy;
	wire tx_fire = (gen_q == ST_RUN) && tx_rdy;
	wire last_beat = tx_fire && (phase_q == PKT_LAST_PHASE);
	wire gen_end = last_beat && (pairs_q == NPAIRS - 16'h0001);
	wire [7:0] ch1 = burst ? BURST_CH_B : ch0_q + 8'h01;
	wire [7:0] ch0_next = burst ? BURST_CH_A : ch0_q + 8'h02;
	wire rx_eop0 = rx_beat[0].ena && rx_beat[0].eop;
	wire rx_eop1 = rx_beat[1].ena && rx_beat[1].eop;
	wire [16:0] rx_cnt_d = rx_cnt_q + {16'h0000, rx_eop0} + {16'h0000, rx_eop1};
	wire mon_end = (mon_q == ST_RUN) && (rx_cnt_d == NPKTS);

	// Generator next state
	always_comb
	begin
		gen_d = gen_q;
		case (gen_q)
			ST_IDLE:
				// Restart starts a new run
				if (restart_ok)
					gen_d = ST_WAIT;
			ST_WAIT:
				// hold until link and remote ready
				if (gen_go)
					gen_d = ST_RUN;
			ST_RUN:
				// back to idle after last packet
				if (gen_end)
					gen_d = ST_IDLE;
			default:
				gen_d = ST_IDLE;
		endcase
	end

	// Monitor next state
	always_comb
	begin
		mon_d = mon_q;
		case (mon_q)
			ST_IDLE:
				if (restart_ok)
					mon_d = ST_WAIT;
			ST_WAIT:
				if (link_up)
					mon_d = ST_RUN;
			ST_RUN:
				if (mon_end)
					mon_d = ST_IDLE;
			default:
				mon_d = ST_IDLE;
		endcase
	end

	// three-segment packets: phase 0 sop|mid, 1 eop|sop, 2 mid|eop
	always_comb
	begin
		tx_beat_d = '0;
		if (tx_fire)
		begin
			tx_beat_d[0].ena = 1'b1;
			tx_beat_d[1].ena = 1'b1;
			tx_beat_d[0].sop = (phase_q == 2'h0);
			tx_beat_d[0].eop = (phase_q == 2'h1);
			tx_beat_d[1].sop = (phase_q == 2'h1);
			tx_beat_d[1].eop = (phase_q == 2'h2);
			tx_beat_d[0].chan = (phase_q == 2'h2) ? ch1 : ch0_q;
			tx_beat_d[1].chan = (phase_q == 2'h0) ? ch0_q : ch1;
			tx_beat_d[0].data = {pairs_q, 14'h0000, phase_q};
			tx_beat_d[1].data = {pairs_q, 14'h0001, phase_q};
		end
	end

	// State registers; reset puts both machines straight into wait, no restart needed
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			gen_q <= ST_WAIT;
			mon_q <= ST_WAIT;
			restart_prev_q <= 1'b0;
		end
		else
		begin
			gen_q <= gen_d;
			mon_q <= mon_d;
			restart_prev_q <= pin_in[0];
		end
	end

	// Generator sequence counters and drive
	always_ff @(posedge clk)
	begin
		if (!rstn || restart_ok)
		begin
			phase_q <= 2'h0;
			pairs_q <= 16'h0000;
			ch0_q <= burst ? BURST_CH_A : 8'h00;
			tx_beat <= '0;
			done_q <= 1'b0;
		end
		else
		begin
			tx_beat <= tx_beat_d;
			if (gen_end)
				done_q <= 1'b1;
			if (last_beat)
			begin
				phase_q <= 2'h0;
				pairs_q <= pairs_q + 16'h0001;
				ch0_q <= ch0_next;
			end
			else if (tx_fire)
				phase_q <= phase_q + 2'h1;
		end
	end

	// flow control enables and one error injection per run
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			in_band_flow_control_en <= 1'b0;
			out_of_band_flow_control_en <= 1'b0;
			err_inject <= 1'b0;
		end
		else
		begin
			in_band_flow_control_en <= ctrl_q[CB_IN_BAND_FLOW_CONTROL] && (gen_q == ST_RUN);
			out_of_band_flow_control_en <= ctrl_q[CB_OUT_OF_BAND_FLOW_CONTROL] && (gen_q == ST_RUN);
			err_inject <= ctrl_q[CB_ERRINJ] && (gen_q == ST_WAIT) && gen_go;
		end
	end

	// Monitor counting and checks; events win over a restart clear
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			rx_cnt_q <= '0;
			exp_ch_q <= 8'h00;
			rx_done_q <= 1'b0;
			rx_err_q <= 1'b0;
			fc_err_q <= 1'b0;
			inj_seen_q <= 1'b0;
			fail_q <= 1'b0;
		end
		else
		begin
			fail_q <= (fail_q && !restart_ok) || tx_ovf || tx_unf;
			fc_err_q <= (fc_err_q && !restart_ok) || fc_mon_err;
			inj_seen_q <= (inj_seen_q && !restart_ok) || err_inj_status;
			if (restart_ok)
			begin
				rx_cnt_q <= '0;
				exp_ch_q <= burst ? BURST_CH_A : 8'h00;
				rx_done_q <= 1'b0;
				rx_err_q <= 1'b0;
			end
			else if (mon_q == ST_RUN)
			begin
				rx_cnt_q <= rx_cnt_d;
				if (mon_end)
					rx_done_q <= 1'b1;
				// Channel check on each start of packet
				if (rx_beat[0].ena && rx_beat[0].sop)
				begin
					rx_err_q <= rx_err_q || (rx_beat[0].chan != exp_ch_q);
					exp_ch_q <= burst ? BURST_CH_B : exp_ch_q + 8'h01;
				end
				else if (rx_beat[1].ena && rx_beat[1].sop)
				begin
					rx_err_q <= rx_err_q || (rx_beat[1].chan != exp_ch_q);
					exp_ch_q <= burst ? BURST_CH_A : exp_ch_q + 8'h01;
				end
			end
		end
	end

	// bit reversal toward and from the transceiver
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			xcvr_txd <= '0;
			core_rxd <= '0;
		end
		else
		begin
			xcvr_txd <= {<<{core_txd}};
			core_rxd <= {<<{xcvr_rxd}};
		end
	end

	assign led_src = {rx_fail_src(), mon_busy, gen_busy, fail_q, done_q,
		rx_aligned, rx_locked, tx_locked};
	function automatic logic rx_fail_src();
		return rx_err_q || fc_err_q;
	endfunction : rx_fail_src
	assign transmit_transceiver_locked_indicator = led_out[0];
	assign receive_transceiver_locked_indicator = led_out[1];
	assign rx_aligned_led = led_out[2];
	assign tx_done_led = led_out[3];
	assign tx_fail_led = led_out[4];
	assign tx_busy_led = led_out[5];
	assign rx_busy_led = led_out[6];
	assign rx_fail_led = led_out[7];

	// Register slave: one wait cycle, then answer
	wire req = (read || write) && waitrequest;
	wire wr_ctrl = write && !waitrequest && (address == OFS_CTRL);
	wire [31:0] stat_word = {23'h000000, inj_seen_q, fc_err_q, rx_err_q,
		rx_done_q, mon_busy, fail_q, done_q, gen_busy};
	wire [31:0] rd_mux = (address == OFS_CTRL) ? {27'h0000000, ctrl_q} :
		(address == OFS_STAT) ? stat_word :
		(address == OFS_TXCNT) ? {15'h0000, pairs_q, 1'b0} :
		(address == OFS_RXCNT) ? {15'h0000, rx_cnt_q} : 32'h00000000;
	assign ctrl_d = wr_ctrl ? writedata[4:0] : ctrl_q;

	// Bus handshake and control register
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			waitrequest <= 1'b1;
			readdata <= 32'h00000000;
			ctrl_q <= CTRL_RST;
			restart_sw_q <= 1'b0;
		end
		else
		begin
			waitrequest <= !req;
			if (req)
				readdata <= rd_mux;
			ctrl_q <= ctrl_d;
			restart_sw_q <= wr_ctrl && writedata[CB_RESTART];
		end
	end

	// Checks
	a_pkt_count_legal: assert property (@(posedge clk)
		NUM_PKTS % 2 == 0 && NUM_PKTS >= NUM_PKTS_MIN && NUM_PKTS <= NUM_PKTS_MAX)
		else $error("packet count illegal");
	a_gen_link_wait: assert property (@(posedge clk) disable iff (!rstn)
		(gen_q == ST_WAIT && !link_up) |=> gen_q == ST_WAIT)
		else $error("generator left wait without link");
	a_mon_link_wait: assert property (@(posedge clk) disable iff (!rstn)
		(mon_q == ST_WAIT) |=> (mon_q == ST_RUN) == $past(link_up))
		else $error("monitor wait wrong");
	a_chan_count: assert property (@(posedge clk) disable iff (!rstn)
		(tx_fire && phase_q == 2'h0 && !burst) |=> tx_beat[0].chan == $past(pairs_q[6:0]) * 2)
		else $error("packet channel wrong");
	a_burst_pair: assert property (@(posedge clk) disable iff (!rstn)
		(tx_fire && phase_q == 2'h1 && burst && ch0_q == BURST_CH_A)
		|=> tx_beat[0].chan == BURST_CH_A && tx_beat[1].chan == BURST_CH_B)
		else $error("burst channels wrong");
	a_restart_blocked: assert property (@(posedge clk) disable iff (!rstn)
		(gen_q == ST_IDLE && mon_busy) |=> gen_q == ST_IDLE)
		else $error("restart taken while busy");
	a_simplex_hold: assert property (@(posedge clk) disable iff (!rstn)
		(gen_q == ST_WAIT && simplex && !pin_in[1]) |=> gen_q == ST_WAIT)
		else $error("simplex start early");
	a_done_count: assert property (@(posedge clk) disable iff (!rstn)
		$rose(done_q) |-> pairs_q == NPAIRS && gen_q == ST_IDLE)
		else $error("done without all packets");
	a_fail_sticky: assert property (@(posedge clk) disable iff (!rstn)
		(tx_ovf || tx_unf) |=> fail_q)
		else $error("fifo error missed");
	a_led_three_stage: assert property (@(posedge clk) disable iff (!rstn)
		$past(rstn, 3) |-> led_out == $past(led_src, 3))
		else $error("indicator stages wrong");
	a_bit_swap: assert property (@(posedge clk) disable iff (!rstn)
		$past(rstn) |-> xcvr_txd[0] == $past(core_txd[XDW-1]))
		else $error("bit swap wrong");
	c_run_done: cover property (@(posedge clk) disable iff (!rstn) $rose(done_q));
	c_rx_done: cover property (@(posedge clk) disable iff (!rstn) $rose(rx_done_q));
	c_restart: cover property (@(posedge clk) disable iff (!rstn) restart_ok);
endmodule : traffic_tester

// [verif/core_model.sv]
// Behavioural protocol core facing the tester, looping traffic back.
// Assumes the tester's clk; link state and pacing come from the bench.
`timescale 1ns/1ps
module core_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Bench controls
	input wire logic link_up,
	input wire logic slow,
	// Tester side
	input wire traffic_pkg::beat_t tx_beat,
	output logic tx_locked,
	output logic rx_locked,
	output logic rx_aligned,
	output logic tx_rdy,
	output traffic_pkg::beat_t rx_beat
);
	import traffic_pkg::*;
	// Toggle that gaps ready in slow mode
	logic pace_q;
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			{tx_locked, rx_locked, rx_aligned, tx_rdy, pace_q} <= 5'h00;
			rx_beat <= '0;
		end
		else
		begin
			tx_locked <= link_up;
			rx_locked <= link_up;
			// Alignment lags lock by a cycle
			rx_aligned <= rx_locked;
			pace_q <= !pace_q;
			tx_rdy <= link_up && (!slow || pace_q);
			// Idle bus shows junk with ena low: the last beat inverted, then repeated, in turn
			if (tx_beat[0].ena || tx_beat[1].ena)
				rx_beat <= tx_beat;
			else
			begin
				rx_beat <= ~rx_beat;
				rx_beat[0].ena <= 1'b0;
				rx_beat[1].ena <= 1'b0;
			end
		end
	end
endmodule : core_model

// [verif/packet_traffic_gen_monitor_bench.sv]
// Self-checking bench: tester, core model, Avalon tasks, scenarios.
// Assumes traffic_pkg; packet count set just past one channel wrap.
`timescale 1ns/1ps
module packet_traffic_gen_monitor_bench;
	import traffic_pkg::*;
	localparam int NP = 258;
	logic clk, rstn, read, write, waitrequest, link_up, slow, tx_rdy;
	logic tx_ovf, tx_unf, inj_st, fc_err, tx_locked, rx_locked, rx_aligned;
	logic in_band_flow_control, out_of_band_flow_control, err_inject, restart_pin, smp_pin;
	logic [3:0] address;
	logic [31:0] writedata, readdata, rd;
	logic [XDW-1:0] core_txd, xcvr_txd, xcvr_rxd, core_rxd;
	// Tx lock, rx lock, aligned, done, tx fail, tx busy, rx busy, rx fail
	wire logic [7:0] leds;
	beat_t tx_beat, rx_beat;
	int fail_count = 0;
	int n_checks = 0;

	traffic_tester #(.NUM_PKTS(NP)) u_traffic_tester (
		.clk(clk), .rstn(rstn), .address(address), .read(read), .write(write),
		.writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
		.tx_locked(tx_locked), .rx_locked(rx_locked), .rx_aligned(rx_aligned),
		.tx_ovf(tx_ovf), .tx_unf(tx_unf), .err_inj_status(inj_st), .fc_mon_err(fc_err),
		.tx_rdy(tx_rdy), .tx_beat(tx_beat), .rx_beat(rx_beat),
		.in_band_flow_control_en(in_band_flow_control), .out_of_band_flow_control_en(out_of_band_flow_control),
		.err_inject(err_inject), .core_txd(core_txd), .xcvr_txd(xcvr_txd),
		.xcvr_rxd(xcvr_rxd), .core_rxd(core_rxd), .restart_pin(restart_pin),
		.simplex_rx_aligned_pin(smp_pin), .transmit_transceiver_locked_indicator(leds[7]),
		.receive_transceiver_locked_indicator(leds[6]), .rx_aligned_led(leds[5]),
		.tx_done_led(leds[4]), .tx_fail_led(leds[3]), .tx_busy_led(leds[2]),
		.rx_busy_led(leds[1]), .rx_fail_led(leds[0]));

	core_model u_core_model (
		.clk(clk), .rstn(rstn), .link_up(link_up), .slow(slow), .tx_beat(tx_beat),
		.tx_locked(tx_locked), .rx_locked(rx_locked), .rx_aligned(rx_aligned),
		.tx_rdy(tx_rdy), .rx_beat(rx_beat));

	// Free-running 40 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		n_checks++;
		if (got !== exp)
		begin
			$display("mismatch %s expected %h seen %h", what, exp, got);
			fail_count++;
		end
	endtask : chk

	// One Avalon access; holds everything until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		address <= a;
		writedata <= d;
		write <= wr;
		read <= !wr;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (waitrequest !== 1'b0 && n < 50);
		rd = readdata;
		write <= 1'b0;
		read <= 1'b0;
		chk("bus answer", 1, n < 50);
	endtask : bus

	// Bounded wait for one indicator to reach a level
	task automatic await(input int b, input logic v, input int lim, input string what);
		int n;
		n = 0;
		while (leds[b] !== v && n < lim)
		begin
			@(negedge clk);
			n++;
		end
		chk(what, v, leds[b]);
	endtask : await

	function automatic logic [7:0] chan_of(input int k, input logic burst);
		if (burst)
			return k % 2 ? BURST_CH_B : BURST_CH_A;
		return 8'(k % 256);
	endfunction : chan_of

	// Follows one whole run, beat by beat, then checks the end state
	task automatic run_check(input logic burst, input string what);
		int ph, pk, n, inj;
		logic clr;
		ph = 0;
		pk = 0;
		n = 0;
		inj = 0;
		// Watch from the call on; the old done indicator outlives the first beats
		clr = (leds[4] === 1'b0);
		while (!(clr && leds[4] === 1'b1) && n < 1500)
		begin
			@(negedge clk);
			n++;
			clr = clr || (leds[4] === 1'b0);
			inj += int'(err_inject === 1'b1);
			if (tx_beat[0].ena === 1'b1)
			begin
				chk("markers", ph == 0 ? 4'h8 : ph == 1 ? 4'h6 : 4'h1, {tx_beat[0].sop,
					tx_beat[0].eop, tx_beat[1].sop, tx_beat[1].eop});
				chk("chan0", chan_of(pk + (ph == 2), burst), tx_beat[0].chan);
				chk("chan1", chan_of(pk + (ph != 0), burst), tx_beat[1].chan);
				if (burst)
					chk("fc enables", 2'h3, {in_band_flow_control, out_of_band_flow_control});
				pk += ph == 2 ? 2 : 0;
				ph = (ph + 1) % 3;
			end
		end
		chk("done clear", 1, clr);
		chk("done led", 1, leds[4]);
		chk("packets", NP, pk);
		if (burst)
			chk("inject pulses", 1, inj);
		await(2, 1'b0, 20, "tx idle");
		await(1, 1'b0, 40, "rx idle");
		bus(1'b0, OFS_TXCNT, 32'h0);
		chk("sent count", NP, rd);
		bus(1'b0, OFS_RXCNT, 32'h0);
		chk("received count", NP, rd);
		chk("rx fail", 0, leds[0]);
		$display("test %s done", what);
	endtask : run_check

	task automatic t_wait_link();
		int n;
		n = 0;
		repeat (12)
		begin
			@(negedge clk);
			n += int'(tx_beat[0].ena !== 1'b0 || tx_beat[1].ena !== 1'b0);
		end
		chk("beats before link", 0, n);
		chk("busy leds", 2'h3, leds[2:1]);
		bus(1'b0, OFS_CTRL, 32'h0);
		chk("ctrl reset", 32'(CTRL_RST), rd);
		bus(1'b0, 4'h1, 32'h0);
		chk("unmapped read", 0, rd);
		$display("test wait_link done");
	endtask : t_wait_link

	task automatic t_link_packet();
		@(posedge clk);
		slow <= 1'b1;
		link_up <= 1'b1;
		repeat (2) @(negedge clk);
		chk("lock led early", 0, leds[7]);
		run_check(1'b0, "packet");
		chk("lock and align leds", 3'h7, leds[7:5]);
		slow <= 1'b0;
	endtask : t_link_packet

	task automatic t_simplex();
		int n;
		n = 0;
		bus(1'b1, OFS_CTRL, 32'h22);
		repeat (20)
		begin
			@(negedge clk);
			n += int'(tx_beat[0].ena === 1'b1);
		end
		chk("beats unaligned", 0, n);
		@(posedge clk);
		smp_pin <= 1'b1;
		run_check(1'b0, "simplex");
	endtask : t_simplex

	task automatic t_pin_restart();
		bus(1'b1, OFS_CTRL, 32'h00);
		restart_pin <= 1'b1;
		repeat (4) @(posedge clk);
		restart_pin <= 1'b0;
		run_check(1'b0, "pin restart");
	endtask : t_pin_restart

	task automatic t_fail_swap();
		tx_ovf <= 1'b1;
		@(posedge clk);
		tx_ovf <= 1'b0;
		await(3, 1'b1, 10, "overflow fail");
		bus(1'b1, OFS_CTRL, 32'h20);
		await(3, 1'b0, 20, "fail cleared");
		@(posedge clk);
		tx_unf <= 1'b1;
		@(posedge clk);
		tx_unf <= 1'b0;
		await(3, 1'b1, 10, "underflow fail");
		@(posedge clk);
		fc_err <= 1'b1;
		inj_st <= 1'b1;
		@(posedge clk);
		fc_err <= 1'b0;
		inj_st <= 1'b0;
		await(0, 1'b1, 10, "flow monitor fail");
		// Injection seen, flow error, no channel error, fifo fail
		bus(1'b0, OFS_STAT, 32'h0);
		chk("status flags", 4'hd, {rd[7:5], rd[2]});
		@(posedge clk);
		core_txd <= 64'h1;
		xcvr_rxd <= 64'h0123456789abcdef;
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk("tx swap", 64'h8000000000000000, xcvr_txd);
		chk("rx swap", 64'hf7b3d591e6a2c480, core_rxd);
		$display("test fail_swap done");
	endtask : t_fail_swap

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : tally_and_finish

	// Main sequence
	initial
	begin
		{rstn, read, write, link_up, slow, tx_ovf, tx_unf} = 7'h00;
		{inj_st, fc_err, restart_pin, smp_pin} = 4'h0;
		{address, writedata, core_txd, xcvr_rxd} = '0;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		t_wait_link();
		t_link_packet();
		bus(1'b1, OFS_CTRL, 32'h3d);
		run_check(1'b1, "burst");
		t_simplex();
		t_pin_restart();
		t_fail_swap();
		tally_and_finish();
	end

	// Watchdog well beyond four runs of the packet count
	initial
	begin
		#(25 * 20000);
		fail_count++;
		tally_and_finish();
	end
endmodule : packet_traffic_gen_monitor_bench
